//--- rtl/mem_prog_pkg.sv
// constants, types and state encodings of the memory programming logic
// assumes one 100 MHz system clock and a synchronous active-high reset
// Notes on behaviour
// - full erase clears flash, ram, data memory, locks
// - keep fuse spares data memory on erase
// - select 10, byte 0, strobe loads command
// - command 1000_0000 means full erase
// - write strobe low starts erase, busy shown
// - command 0001_0000 means write program flash
// - select 00, byte 0 loads address low
// - select 01 loads a data byte
// - byte select 1 picks data high byte
// - words gather in page buffer, written together
// - page load shifts lsb first word first
package mem_prog_pkg;
   // load-select field codes
   localparam logic [1:0] SEL_ADDR = 2'h0;
   localparam logic [1:0] SEL_DATA = 2'h1;
   localparam logic [1:0] SEL_CMD = 2'h2;
   // command bytes
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
   // scan instruction codes seen on scan_instr
   localparam logic [1:0] SCAN_CMD = 2'h0;
   localparam logic [1:0] SCAN_LOAD = 2'h1;
   localparam logic [1:0] SCAN_READ = 2'h2;
   // erased memory contents and lock reset value
   localparam logic [15:0] ERASED_WORD = 16'hffff;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [1:0] LOCK_RESET = 2'h3;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PAGE_WRITE_TIME_NS = 4500;
   localparam int PAGE_WRITE_CYCLES = (PAGE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_SKIP_BITS = 8;
   localparam int FIFO_DEPTH = 16;
   // sequencer states, gray along idle -> erase -> write
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_WRITE = 2'b11
   } seq_state_t;
endpackage

//--- rtl/memory_programming_interface.sv
// programming sequencer: parallel and scan loading, page write, full erase
// assumes programmer pins are asynchronous to sys_clk and slower than it
`timescale 1ns/1ns
module memory_programming_interface
   import mem_prog_pkg::*;
#(
   parameter int PAGE_WORDS = 64,
   parameter int FLASH_WORDS = 16384,
   parameter int DATA_BYTES = 1024,
   parameter int PW_CYCLES = PAGE_WRITE_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // parallel programming pins
   input wire logic load_strobe,
   input wire logic write_strobe_n,
   input wire logic load_select_hi,
   input wire logic load_select_lo,
   input wire logic byte_select,
   input wire logic [7:0] data_in,
   output logic ready_busy_n,
   output logic load_ready,
   // scan programming pins
   input wire logic scan_tck,
   input wire logic scan_tdi,
   input wire logic scan_shift,
   input wire logic [1:0] scan_instr,
   output logic scan_tdo,
   // fuse, lock and memory status
   input wire logic data_memory_keep_fuse,
   output logic [1:0] lock_bits,
   output logic ram_erase,
   input wire logic [$clog2(DATA_BYTES)-1:0] data_rd_addr,
   output logic [7:0] data_rd_byte
);
   localparam int PB = $clog2(PAGE_WORDS);
   localparam int FA = $clog2(FLASH_WORDS);
   localparam int DA = $clog2(DATA_BYTES);
   localparam int CW = $clog2(PW_CYCLES + 1);
   localparam int RW = $clog2(READ_SKIP_BITS + 16 * PAGE_WORDS + 1);
   localparam int NS = 18;
   localparam logic [FA-1:0] LAST_FLASH = FA'(FLASH_WORDS - 1);
   localparam logic [CW-1:0] LAST_WRITE = CW'(PW_CYCLES - 1);
   localparam logic [RW-1:0] SKIP = RW'(READ_SKIP_BITS);

   // pin synchronisers
   logic [NS-1:0] pin_raw, s1_ff, s2_ff, s3_ff;
   assign pin_raw = {load_strobe, write_strobe_n, load_select_hi, load_select_lo, byte_select,
                     scan_tck, scan_tdi, scan_shift, scan_instr, data_in};
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= pin_raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   logic [7:0] dat;
   logic [1:0] instr, sel;
   logic shift, tdi, bs, ld_rise, wr_fall, tck_rise;
   assign dat = s2_ff[7:0];
   assign instr = s2_ff[9:8];
   assign shift = s2_ff[10];
   assign tdi = s2_ff[11];
   assign bs = s2_ff[13];
   assign sel = s2_ff[15:14];
   assign tck_rise = s2_ff[12] && !s3_ff[12];
   assign wr_fall = !s2_ff[16] && s3_ff[16];
   assign ld_rise = s2_ff[17] && !s3_ff[17];

   // parallel byte loading
   logic [7:0] cmd_ff, data_lo_ff;
   logic [15:0] addr_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_ff <= '0;
         addr_ff <= '0;
         data_lo_ff <= '0;
      end else if (ld_rise) begin
         case (sel)
            SEL_CMD: begin
               if (!bs) cmd_ff <= dat;
            end
            SEL_ADDR: begin
               if (bs) addr_ff[15:8] <= dat;
               else addr_ff[7:0] <= dat;
            end
            SEL_DATA: begin
               if (!bs) data_lo_ff <= dat;
            end
            default: begin
            end
         endcase
      end
   end

   // scan page load shifter
   logic [15:0] ld_sh_ff;
   logic [3:0] ld_bits_ff;
   logic [PB-1:0] ld_idx_ff;
   logic scan_step_ld, scan_push, par_push;
   assign scan_step_ld = tck_rise && shift && (instr == SCAN_LOAD);
   assign scan_push = scan_step_ld && (ld_bits_ff == 4'hf);
   assign par_push = ld_rise && (sel == SEL_DATA) && bs;
   always_ff @(posedge sys_clk) begin
      if (rst || instr != SCAN_LOAD) begin
         ld_sh_ff <= '0;
         ld_bits_ff <= '0;
         ld_idx_ff <= '0;
      end else if (scan_step_ld) begin
         ld_sh_ff <= {tdi, ld_sh_ff[15:1]};
         ld_bits_ff <= ld_bits_ff + 1'b1;
         if (scan_push) ld_idx_ff <= ld_idx_ff + 1'b1;
      end
   end

   // word fifo in front of the page buffer
   seq_state_t state_ff;
   stream_if #(.W(16 + PB)) fin ();
   stream_if #(.W(16 + PB)) fout ();
   assign fin.valid = par_push || scan_push;
   assign fin.data = par_push ? {addr_ff[PB-1:0], dat, data_lo_ff}
                              : {ld_idx_ff, tdi, ld_sh_ff[15:1]};
   assign fout.ready = (state_ff == ST_IDLE);
   assign load_ready = fin.ready;
   word_fifo #(.W(16 + PB), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_s(fin),
      .out_s(fout)
   );

   // sequencer
   logic pend_erase_ff, pend_write_ff;
   logic [FA-1:0] erase_cnt_ff;
   logic [CW-1:0] wr_cnt_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
         pend_erase_ff <= 1'b0;
         pend_write_ff <= 1'b0;
         erase_cnt_ff <= '0;
         wr_cnt_ff <= '0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (wr_fall) begin
                  pend_erase_ff <= (cmd_ff == CMD_ERASE);
                  pend_write_ff <= (cmd_ff == CMD_WRITE_FLASH);
               end else if (!fout.valid && pend_erase_ff) begin
                  pend_erase_ff <= 1'b0;
                  erase_cnt_ff <= '0;
                  state_ff <= ST_ERASE;
               end else if (!fout.valid && pend_write_ff) begin
                  pend_write_ff <= 1'b0;
                  wr_cnt_ff <= '0;
                  state_ff <= ST_WRITE;
               end
            end
            ST_ERASE: begin
               erase_cnt_ff <= erase_cnt_ff + 1'b1;
               if (erase_cnt_ff == LAST_FLASH) state_ff <= ST_IDLE;
            end
            ST_WRITE: begin
               wr_cnt_ff <= wr_cnt_ff + 1'b1;
               if (wr_cnt_ff == LAST_WRITE) state_ff <= ST_IDLE;
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end
   assign ready_busy_n = (state_ff == ST_IDLE) && !pend_erase_ff && !pend_write_ff;
   assign ram_erase = (state_ff == ST_ERASE);

   // lock bits drop only once the whole flash is erased
   logic [1:0] lock_ff;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lock_ff <= LOCK_RESET;
      end else if (state_ff == ST_ERASE && erase_cnt_ff == LAST_FLASH) begin
         lock_ff <= '0;
      end
   end
   assign lock_bits = lock_ff;

   // memories
   logic [15:0] pbuf [PAGE_WORDS];
   logic [15:0] flash_mem [FLASH_WORDS];
   logic [7:0] data_mem [DATA_BYTES];
   logic dm_clear, fl_page_we;
   assign dm_clear = (state_ff == ST_ERASE) && !data_memory_keep_fuse
                     && ({1'b0, erase_cnt_ff} < (FA+1)'(DATA_BYTES));
   assign fl_page_we = (state_ff == ST_WRITE) && (wr_cnt_ff < CW'(PAGE_WORDS));
   always_ff @(posedge sys_clk) begin
      if (fout.valid && fout.ready) pbuf[fout.data[16+PB-1:16]] <= fout.data[15:0];
   end
   always_ff @(posedge sys_clk) begin
      if (state_ff == ST_ERASE) begin
         flash_mem[erase_cnt_ff] <= ERASED_WORD;
      end else if (fl_page_we) begin
         flash_mem[{addr_ff[FA-1:PB], wr_cnt_ff[PB-1:0]}] <= pbuf[wr_cnt_ff[PB-1:0]];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (dm_clear) data_mem[erase_cnt_ff[DA-1:0]] <= ERASED_BYTE;
   end
   always_ff @(posedge sys_clk) begin
      if (rst) data_rd_byte <= '0;
      else data_rd_byte <= data_mem[data_rd_addr];
   end

   // scan page read: dummy byte, then page words lsb first
   logic [RW-1:0] rd_cnt_ff, rd_off;
   logic [15:0] rd_word;
   logic tdo_ff;
   assign rd_off = rd_cnt_ff - SKIP;
   assign rd_word = flash_mem[{addr_ff[FA-1:PB], rd_off[PB+3:4]}];
   always_ff @(posedge sys_clk) begin
      if (rst || instr != SCAN_READ) begin
         rd_cnt_ff <= '0;
         tdo_ff <= 1'b0;
      end else if (tck_rise && shift) begin
         tdo_ff <= (rd_cnt_ff < SKIP) ? 1'b0 : rd_word[rd_off[3:0]];
         rd_cnt_ff <= rd_cnt_ff + 1'b1;
      end
   end
   assign scan_tdo = tdo_ff;

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   property p_cmd_capture;
      ld_rise && sel == SEL_CMD && !bs |=> cmd_ff == $past(dat);
   endproperty
   a_cmd_capture: assert property (p_cmd_capture) else $error("command byte not captured");

   property p_erase_decode;
      $rose(state_ff == ST_ERASE) |-> $past(pend_erase_ff) && $past(cmd_ff) == CMD_ERASE;
   endproperty
   a_erase_decode: assert property (p_erase_decode) else $error("erase without erase command");

   sequence s_erase_start;
      state_ff == ST_IDLE && wr_fall && cmd_ff == CMD_ERASE;
   endsequence
   property p_erase_busy;
      s_erase_start |=> !ready_busy_n [*4];
   endproperty
   a_erase_busy: assert property (p_erase_busy) else $error("busy not shown after erase start");

   property p_write_decode;
      $rose(state_ff == ST_WRITE) |-> $past(pend_write_ff) && $past(cmd_ff) == CMD_WRITE_FLASH;
   endproperty
   a_write_decode: assert property (p_write_decode) else $error("page write without write command");

   property p_lock_order;
      lock_ff != $past(lock_ff) |-> $past(state_ff) == ST_ERASE && $past(erase_cnt_ff) == LAST_FLASH;
   endproperty
   a_lock_order: assert property (p_lock_order) else $error("lock bits changed before flash erased");

   property p_keep_fuse;
      data_memory_keep_fuse |-> !dm_clear;
   endproperty
   a_keep_fuse: assert property (p_keep_fuse) else $error("data memory cleared with keep fuse");

   property p_addr_lo;
      ld_rise && sel == SEL_ADDR && !bs |=> addr_ff[7:0] == $past(dat) && $stable(addr_ff[15:8]);
   endproperty
   a_addr_lo: assert property (p_addr_lo) else $error("address low byte not captured");

   property p_data_lo;
      ld_rise && sel == SEL_DATA && !bs |=> data_lo_ff == $past(dat);
   endproperty
   a_data_lo: assert property (p_data_lo) else $error("data low byte not captured");

   property p_data_hi;
      par_push && fin.ready && !fout.valid && ready_busy_n |=> ##2
         pbuf[$past(addr_ff[PB-1:0], 3)] == {$past(dat, 3), $past(data_lo_ff, 3)};
   endproperty
   a_data_hi: assert property (p_data_hi) else $error("high byte misplaced in word");

   property p_page_write;
      $rose(state_ff == ST_WRITE) |-> (fl_page_we && !ready_busy_n) [*8];
   endproperty
   a_page_write: assert property (p_page_write) else $error("page write not held busy");

   property p_scan_word;
      scan_push |-> ld_bits_ff == 4'hf && fin.data[15] == tdi && fin.data[0] == ld_sh_ff[1];
   endproperty
   a_scan_word: assert property (p_scan_word) else $error("scan word assembled out of order");
endmodule // memory_programming_interface

//--- rtl/stream_if.sv
// valid/ready word stream between the loader and the page buffer fifo
// assumes both ends run on sys_clk
`timescale 1ns/1ns
interface stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface // stream_if

//--- rtl/word_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ns
module word_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // fill and drain sides
   stream_if.snk in_s,
   stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
   logic [AW:0] cnt_ff;
   logic push, pop;

   assign in_s.ready = (cnt_ff != FULL_CNT);
   assign out_s.valid = (cnt_ff != '0);
   assign out_s.data = mem[rd_ptr_ff];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wr_ptr_ff] <= in_s.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop) begin
            cnt_ff <= cnt_ff + 1'b1;
         end else if (pop && !push) begin
            cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end
endmodule // word_fifo

//--- tb/programmer_model.sv
// programmer model: drives the parallel and scan programming pins
// assumes sys_clk at 100 MHz; pins change 1 ns after a rising edge
`timescale 1ns/1ns
module programmer_model (
   // clock
   input wire logic sys_clk,
   // parallel pins
   output logic load_strobe,
   output logic write_strobe_n,
   output logic load_select_hi,
   output logic load_select_lo,
   output logic byte_select,
   output logic [7:0] data_in,
   // scan pins
   output logic scan_tck,
   output logic scan_tdi,
   output logic scan_shift,
   output logic [1:0] scan_instr,
   input wire logic scan_tdo
);
   initial begin
      {load_strobe, load_select_hi, load_select_lo, byte_select} = 4'h0;
      write_strobe_n = 1'b1;
      data_in = 8'h00;
      {scan_tck, scan_tdi, scan_shift} = 3'h0;
      scan_instr = 2'h0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // select and data stand well around the strobe pulse
   task automatic load(input logic [1:0] sel, input logic bs, input logic [7:0] d);
      hold(1);
      {load_select_hi, load_select_lo} = sel;
      byte_select = bs;
      data_in = d;
      hold(4);
      load_strobe = 1'b1;
      hold(4);
      load_strobe = 1'b0;
      hold(4);
      data_in = ~d; // released bus no longer shows the byte
   endtask
   task automatic write_pulse();
      hold(1);
      write_strobe_n = 1'b0;
      hold(6);
      write_strobe_n = 1'b1;
   endtask
   task automatic instr(input logic [1:0] code, input logic sh);
      hold(1);
      scan_instr = code;
      scan_shift = sh;
      hold(4);
   endtask
   // slow test clock, still between bits
   task automatic scan_bit(input logic b, output logic q);
      hold(1);
      scan_tdi = b;
      hold(2);
      scan_tck = 1'b1;
      hold(6);
      q = scan_tdo;
      scan_tck = 1'b0;
      hold(4);
      scan_tdi = ~b;
   endtask
endmodule // programmer_model

//--- tb/tb_memory_programming_interface.sv
// testbench: erase, parallel and scan page programming, scan page read
// assumes the programmer model in tb/ and the design package
`timescale 1ns/1ns
module tb_memory_programming_interface;
   import mem_prog_pkg::*;
   localparam int PW = 8;
   localparam int FW = 256;
   localparam int PWC = 70;
   logic sys_clk, rst, load_strobe, write_strobe_n, load_select_hi, load_select_lo;
   logic byte_select, ready_busy_n, load_ready, scan_tck, scan_tdi, scan_shift, scan_tdo;
   logic data_memory_keep_fuse, ram_erase;
   logic [7:0] data_in, data_rd_addr, data_rd_byte;
   logic [1:0] scan_instr, lock_bits;
   int errors = 0;
   int check_count = 0;
   int flash_m [FW];

   memory_programming_interface #(.PAGE_WORDS(PW), .FLASH_WORDS(FW), .DATA_BYTES(FW),
      .PW_CYCLES(PWC)) DUT (.sys_clk(sys_clk), .rst(rst), .load_strobe(load_strobe),
      .write_strobe_n(write_strobe_n), .load_select_hi(load_select_hi),
      .load_select_lo(load_select_lo), .byte_select(byte_select), .data_in(data_in),
      .ready_busy_n(ready_busy_n), .load_ready(load_ready), .scan_tck(scan_tck),
      .scan_tdi(scan_tdi), .scan_shift(scan_shift), .scan_instr(scan_instr),
      .scan_tdo(scan_tdo), .data_memory_keep_fuse(data_memory_keep_fuse),
      .lock_bits(lock_bits), .ram_erase(ram_erase), .data_rd_addr(data_rd_addr),
      .data_rd_byte(data_rd_byte));
   programmer_model pm (.sys_clk(sys_clk), .load_strobe(load_strobe),
      .write_strobe_n(write_strobe_n), .load_select_hi(load_select_hi),
      .load_select_lo(load_select_lo), .byte_select(byte_select), .data_in(data_in),
      .scan_tck(scan_tck), .scan_tdi(scan_tdi), .scan_shift(scan_shift),
      .scan_instr(scan_instr), .scan_tdo(scan_tdo));

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // start the loaded command, then count busy cycles under a bound
   task automatic op(input logic is_erase, input int lim, output int busy);
      pm.write_pulse();
      check(ready_busy_n, 1'b0);
      check(ram_erase, is_erase);
      busy = 0;
      while (ready_busy_n !== 1'b1 && busy < lim) begin
         @(posedge sys_clk);
         #1;
         busy++;
      end
   endtask
   task automatic erase(input logic keep);
      int b;
      data_memory_keep_fuse = keep;
      pm.load(SEL_CMD, 1'b0, CMD_ERASE);
      op(1'b1, FW + 50, b);
      check(b >= FW - 8 && b < FW + 50, 1'b1);
      check(lock_bits, 2'h0);
      check(ram_erase, 1'b0);
      for (int i = 0; i < FW; i++) flash_m[i] = 'hffff;
      for (int i = 0; i < 4; i++) begin
         data_rd_addr = 8'($urandom);
         pm.hold(2);
         if (keep) check(data_rd_byte !== ERASED_BYTE, 1'b1);
         else check(data_rd_byte, ERASED_BYTE);
      end
      $display("test erase keep=%0d done", keep);
   endtask
   task automatic page_read(input int pg);
      logic q;
      logic [15:0] w;
      pm.load(SEL_ADDR, 1'b0, 8'(pg * PW));
      pm.instr(SCAN_READ, 1'b1);
      for (int i = 0; i < READ_SKIP_BITS; i++) pm.scan_bit(1'b0, q);
      for (int k = 0; k < PW; k++) begin
         for (int j = 0; j < 16; j++) begin
            pm.scan_bit(1'b0, q);
            w[j] = q;
         end
         check(w, 16'(flash_m[pg * PW + k]));
      end
      pm.instr(SCAN_CMD, 1'b0);
      $display("test page read %0d done", pg);
   endtask
   // single word: address, then shift only as far as that word
   task automatic word_read(input int pg, input int k);
      logic q;
      logic [15:0] w;
      pm.load(SEL_ADDR, 1'b0, 8'(pg * PW + k));
      pm.instr(SCAN_READ, 1'b1);
      for (int i = 0; i < READ_SKIP_BITS + 16 * (k + 1); i++) begin
         pm.scan_bit(1'b0, q);
         w = {q, w[15:1]};
      end
      check(w, 16'(flash_m[pg * PW + k]));
      pm.instr(SCAN_CMD, 1'b0);
      $display("test word read %0d done", k);
   endtask
   task automatic finish_page(input int pg);
      int b;
      op(1'b0, PWC + 30, b);
      check(b >= PWC - 4 && b < PWC + 30, 1'b1);
      page_read(pg);
   endtask
   task automatic par_write(input int pg);
      logic [15:0] d;
      pm.load(SEL_CMD, 1'b0, CMD_WRITE_FLASH);
      for (int k = 0; k < PW; k++) begin
         d = 16'($urandom);
         flash_m[pg * PW + k] = d;
         pm.load(SEL_ADDR, 1'b0, 8'(pg * PW + k));
         pm.load(SEL_DATA, 1'b0, d[7:0]);
         pm.load(SEL_DATA, 1'b1, d[15:8]);
      end
      finish_page(pg);
   endtask
   task automatic scan_write(input int pg);
      logic q;
      logic [15:0] d;
      pm.load(SEL_CMD, 1'b0, CMD_WRITE_FLASH);
      pm.load(SEL_ADDR, 1'b0, 8'(pg * PW));
      pm.instr(SCAN_LOAD, 1'b1);
      for (int k = 0; k < PW; k++) begin
         d = 16'($urandom);
         flash_m[pg * PW + k] = d;
         for (int j = 0; j < 16; j++) pm.scan_bit(d[j], q);
      end
      pm.instr(SCAN_CMD, 1'b0);
      finish_page(pg);
   endtask

   initial begin
      void'($urandom(32'h5a91b1b7));
      rst = 1'b1;
      data_memory_keep_fuse = 1'b0;
      data_rd_addr = 8'h00;
      repeat (2) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      pm.hold(2);
      check(ready_busy_n, 1'b1);
      check(load_ready, 1'b1);
      check(lock_bits, LOCK_RESET);
      check(ram_erase, 1'b0);
      check(scan_tdo, 1'b0);
      $display("test reset done");
      erase(1'b1);
      erase(1'b0);
      page_read(3);
      par_write(5);
      scan_write(9);
      word_read(9, 2);
      par_write(FW / PW - 1);
      results();
   end
   initial begin
      #300_000;
      errors++;
      results();
   end
endmodule // tb_memory_programming_interface
